// ### fpac_flash_ctrl.sv
// Flash control logic: launch key, column latches, code-read gating and boot detect
//
// Contract
// - Data writes go to column latches only when map bit and pin are high.
// - Flash control register clears to zero on reset.
// - Code read from external code with pin low reads external code.
// - External code, pin high, PC upper, bank 3: pointer at/above 8000h reads external.
// - Same case below 8000h is gated by lock level bits.
// - 128-byte pages, each written through a 128-byte column latch area.
// - Erase clears 0000h..1FFFFh, only after security level check; the sequencer starts erase without any lock level check.
// - After full erase all three lock level bits become 1.
// - Boot request when pin high and strobe low during reset.
// - Boot vector config 011 also enters boot at boot address 0000h.
`timescale 1ns/100ps
module fpac_flash_ctrl
   import fpac_pkg::*;
#(
   parameter int PAGE_BYTES = FPAC_PAGE_BYTES,
   parameter int OP_CYCLES = 16
) (
   core_clk,
   sys_rst,
   sfr_bus,
   sfr_rdata,
   xdata_wr,
   xdata_addr,
   xdata_wdata,
   external_access_pin,
   program_store_strobe,
   code_read_move,
   code_from_external,
   pc_upper,
   fetch_bank_select,
   pointer_register,
   flash_rdata,
   boot_vector_config,
   internal_expanded_ram_wr_q,
   latch_wr_q,
   latch_addr_q,
   latch_data_q,
   flash_start_q,
   flash_op_q,
   busy_q,
   lock_level_bits_q,
   ext_code_sel_q,
   code_rdata_q,
   boot_request_q,
   boot_addr_q
);
   input wire logic core_clk;
   input wire logic sys_rst;
   input wire fpac_pkg::fpac_sfr_t sfr_bus;
   output logic [7:0] sfr_rdata;
   input wire logic xdata_wr;
   input wire logic [15:0] xdata_addr;
   input wire logic [7:0] xdata_wdata;
   input wire logic external_access_pin;
   input wire logic program_store_strobe;
   input wire logic code_read_move;
   input wire logic code_from_external;
   input wire logic pc_upper;
   input wire logic [2:0] fetch_bank_select;
   input wire logic [15:0] pointer_register;
   input wire logic [7:0] flash_rdata;
   input wire logic [2:0] boot_vector_config;
   output logic internal_expanded_ram_wr_q;
   output logic latch_wr_q;
   output logic [$clog2(PAGE_BYTES)-1:0] latch_addr_q;
   output logic [7:0] latch_data_q;
   output logic flash_start_q;
   output fpac_pkg::fpac_op_t flash_op_q;
   output logic busy_q;
   output logic [2:0] lock_level_bits_q;
   output logic ext_code_sel_q;
   output logic [7:0] code_rdata_q;
   output logic boot_request_q;
   output logic [15:0] boot_addr_q;

   localparam int AW = $clog2(PAGE_BYTES);
   localparam int CW = $clog2(OP_CYCLES + 1);

   // ****************************************
   // Control register and launch sequencer
   // ****************************************
   fpac_ctrl_t ctrl_q, ctrl_d;
   fpac_state_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic start_d, busy_d;
   logic [2:0] lock_d;
   logic ctrl_wr;
   fpac_ctrl_t wr_val;

   assign ctrl_wr = sfr_bus.wr && (sfr_bus.addr == FPAC_CTRL_ADDR);
   assign wr_val = sfr_bus.data;
   // Key field reads back as zero; keys are write-only strobes
   assign sfr_rdata = (sfr_bus.addr == FPAC_CTRL_ADDR) ?
                      {4'h0, ctrl_q.map_sel, ctrl_q.op} : 8'h00;

   always_comb begin
      ctrl_d = ctrl_q;
      state_d = state_q;
      cnt_d = cnt_q;
      start_d = 1'b0;
      lock_d = lock_level_bits_q;
      if (ctrl_wr) begin
         ctrl_d.map_sel = wr_val.map_sel;
         ctrl_d.op = wr_val.op;
         ctrl_d.key = wr_val.key;
      end
      case (state_q)
         FPAC_IDLE: begin
            if (ctrl_wr && wr_val.key == FPAC_KEY_FIRST) begin
               state_d = FPAC_ARMED;
            end
         end
         FPAC_ARMED: begin
            if (ctrl_wr) begin
               if (wr_val.key == FPAC_KEY_SECOND) begin
                  state_d = FPAC_BUSY;
                  start_d = 1'b1;
                  cnt_d = CW'(OP_CYCLES);
               end else if (wr_val.key != FPAC_KEY_FIRST) begin
                  state_d = FPAC_IDLE;
               end
            end
         end
         FPAC_BUSY: begin
            // Keys written now are ignored, not queued
            if (cnt_q == '0) begin
               state_d = FPAC_IDLE;
               // Launched op decides; op field may be rewritten while busy
               if (flash_op_q == FPAC_OP_ERASE) begin
                  lock_d = FPAC_LOCK_NONE;
               end
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: state_d = FPAC_IDLE;
      endcase
      busy_d = (state_d == FPAC_BUSY);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q <= FPAC_CTRL_RESET;
         state_q <= FPAC_IDLE;
         cnt_q <= '0;
         flash_start_q <= 1'b0;
         flash_op_q <= FPAC_OP_NONE;
         busy_q <= 1'b0;
         lock_level_bits_q <= FPAC_LOCK_NONE;
      end else begin
         ctrl_q <= ctrl_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         flash_start_q <= start_d;
         flash_op_q <= (start_d) ? fpac_op_t'(ctrl_d.op) : flash_op_q;
         busy_q <= busy_d;
         lock_level_bits_q <= lock_d;
      end
   end

   // ****************************************
   // External data write routing
   // ****************************************
   logic to_latch, internal_expanded_ram_d, latch_d;
   always_comb begin
      to_latch = ctrl_q.map_sel && external_access_pin;
      internal_expanded_ram_d = xdata_wr && !to_latch;
      latch_d = xdata_wr && to_latch;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         internal_expanded_ram_wr_q <= 1'b0;
         latch_wr_q <= 1'b0;
         latch_addr_q <= '0;
         latch_data_q <= 8'h00;
      end else begin
         internal_expanded_ram_wr_q <= internal_expanded_ram_d;
         latch_wr_q <= latch_d;
         latch_addr_q <= xdata_addr[AW-1:0];
         latch_data_q <= xdata_wdata;
      end
   end

   // ****************************************
   // Code read gating
   // ****************************************
   logic ext_d;
   logic [7:0] rd_d;
   logic upper_ptr, secure_case;
   always_comb begin
      upper_ptr = (pointer_register >= FPAC_UPPER_HALF);
      secure_case = code_from_external && external_access_pin && pc_upper &&
                    (fetch_bank_select == FPAC_FETCH_BANK3);
      ext_d = 1'b0;
      rd_d = flash_rdata;
      if (code_from_external && !external_access_pin) begin
         ext_d = 1'b1;
      end else if (secure_case && upper_ptr) begin
         ext_d = 1'b1;
      end else if (secure_case && lock_level_bits_q != FPAC_LOCK_NONE) begin
         rd_d = FPAC_JUNK_BYTE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ext_code_sel_q <= 1'b0;
         code_rdata_q <= 8'h00;
      end else begin
         ext_code_sel_q <= code_read_move && ext_d;
         code_rdata_q <= code_read_move ? rd_d : code_rdata_q;
      end
   end

   // ****************************************
   // Boot request detection
   // ****************************************
   logic boot_d;
   always_comb begin
      boot_d = boot_request_q;
      if (sys_rst) begin
         boot_d = (external_access_pin && !program_store_strobe) ||
                  (boot_vector_config == FPAC_BOOT_CFG);
      end
   end

   // Sampled every reset cycle; last value before release is kept
   always_ff @(posedge core_clk) begin
      boot_request_q <= boot_d;
      boot_addr_q <= FPAC_BOOT_ENTRY;
   end
endmodule // fpac_flash_ctrl

// ### fpac_pkg.sv
// Package of constants and types for the flash program access control block
package fpac_pkg;
   // ****************************************
   // Register map and fields
   // ****************************************
   localparam logic [7:0] FPAC_CTRL_ADDR = 8'hd1;
   localparam logic [7:0] FPAC_CTRL_RESET = 8'h00;
   localparam int FPAC_KEY_MSB = 7;
   localparam int FPAC_KEY_LSB = 4;
   localparam int FPAC_MAP_BIT = 3;
   localparam int FPAC_OP_MSB = 2;
   localparam logic [3:0] FPAC_KEY_FIRST = 4'h5;
   localparam logic [3:0] FPAC_KEY_SECOND = 4'ha;
   // ****************************************
   // Memory geometry
   // ****************************************
   localparam logic [15:0] FPAC_UPPER_HALF = 16'h8000;
   localparam logic [16:0] FPAC_ARRAY_LAST = 17'h1_ffff;
   localparam int FPAC_PAGE_BYTES = 128;
   localparam logic [2:0] FPAC_FETCH_BANK3 = 3'h3;
   localparam logic [2:0] FPAC_LOCK_NONE = 3'h7;
   localparam logic [2:0] FPAC_BOOT_CFG = 3'h3;
   localparam logic [15:0] FPAC_BOOT_ENTRY = 16'h0000;
   localparam logic [7:0] FPAC_JUNK_BYTE = 8'hff;
   // ****************************************
   // Operation codes
   // ****************************************
   typedef enum logic [2:0] {
      FPAC_OP_PAGE_WRITE = 3'b000,
      FPAC_OP_ERASE = 3'b001,
      FPAC_OP_SEC_WRITE = 3'b010,
      FPAC_OP_NONE = 3'b111
   } fpac_op_t;
   typedef enum logic [1:0] {
      FPAC_IDLE = 2'b00,
      FPAC_ARMED = 2'b01,
      FPAC_BUSY = 2'b10
   } fpac_state_t;
   typedef struct packed {
      logic [3:0] key;
      logic map_sel;
      logic [2:0] op;
   } fpac_ctrl_t;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } fpac_sfr_t;
endpackage

// ### fpac_flash_ctrl_assertions.sv
// Port checker of the flash control block
`timescale 1ns/100ps
module fpac_flash_ctrl_assertions
   import fpac_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire fpac_pkg::fpac_sfr_t sfr_bus,
   input wire logic [7:0] sfr_rdata,
   input wire logic xdata_wr,
   input wire logic [15:0] xdata_addr,
   input wire logic [7:0] xdata_wdata,
   input wire logic external_access_pin,
   input wire logic program_store_strobe,
   input wire logic code_read_move,
   input wire logic code_from_external,
   input wire logic pc_upper,
   input wire logic [2:0] fetch_bank_select,
   input wire logic [15:0] pointer_register,
   input wire logic [7:0] flash_rdata,
   input wire logic [2:0] boot_vector_config,
   input wire logic internal_expanded_ram_wr_q,
   input wire logic latch_wr_q,
   input wire logic [6:0] latch_addr_q,
   input wire logic [7:0] latch_data_q,
   input wire logic flash_start_q,
   input wire fpac_pkg::fpac_op_t flash_op_q,
   input wire logic busy_q,
   input wire logic [2:0] lock_level_bits_q,
   input wire logic ext_code_sel_q,
   input wire logic [7:0] code_rdata_q,
   input wire logic boot_request_q,
   input wire logic [15:0] boot_addr_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ****************************************
   // Properties
   // ****************************************
   logic ctl;
   logic hi;
   assign ctl = sfr_bus.wr && sfr_bus.addr == FPAC_CTRL_ADDR;
   assign hi = code_read_move && code_from_external && external_access_pin && pc_upper
      && fetch_bank_select == FPAC_FETCH_BANK3;
   property p_launch;
      ctl && sfr_bus.data[7:4] == FPAC_KEY_SECOND && $past(ctl) && !busy_q && !$past(busy_q)
         && $past(sfr_bus.data[7:4]) == FPAC_KEY_FIRST |=> flash_start_q;
   endproperty
   a_launch: assert property (p_launch) else $error("no launch");
   property p_start;
      flash_start_q |-> busy_q ##1 !flash_start_q && busy_q;
   endproperty
   a_start: assert property (p_start) else $error("start or busy wrong");
   property p_route;
      xdata_wr && sfr_bus.addr == FPAC_CTRL_ADDR && !ctl
         |=> latch_wr_q == $past(sfr_rdata[FPAC_MAP_BIT] && external_access_pin)
         && internal_expanded_ram_wr_q != latch_wr_q;
   endproperty
   a_route: assert property (p_route) else $error("write routed wrongly");
   property p_latch;
      latch_wr_q |-> latch_data_q == $past(xdata_wdata) && latch_addr_q == $past(xdata_addr[6:0]);
   endproperty
   a_latch: assert property (p_latch) else $error("latch byte wrong");
   property p_ext;
      code_read_move && code_from_external && !external_access_pin
         || hi && pointer_register >= FPAC_UPPER_HALF |=> ext_code_sel_q;
   endproperty
   a_ext: assert property (p_ext) else $error("no external read");
   property p_gate;
      hi && pointer_register < FPAC_UPPER_HALF && lock_level_bits_q == FPAC_LOCK_NONE
         |=> code_rdata_q == $past(flash_rdata) && !ext_code_sel_q;
   endproperty
   a_gate: assert property (p_gate) else $error("open read wrong");
   property p_erase;
      $fell(busy_q) && flash_op_q == FPAC_OP_ERASE |-> ##[0:1] lock_level_bits_q == FPAC_LOCK_NONE;
   endproperty
   a_erase: assert property (p_erase) else $error("lock not opened");
   property p_boot;
      $past(sys_rst) |-> sfr_rdata == FPAC_CTRL_RESET && boot_addr_q == FPAC_BOOT_ENTRY
         && boot_request_q == ($past(external_access_pin) && !$past(program_store_strobe)
         || $past(boot_vector_config) == FPAC_BOOT_CFG);
   endproperty
   a_boot: assert property (p_boot) else $error("reset state wrong");
   c_launch: cover property (flash_start_q);
   c_latch: cover property (latch_wr_q);
   c_ext: cover property (ext_code_sel_q);
endmodule // fpac_flash_ctrl_assertions

// ### fpac_flash_model.sv
// Flash array read port as the core sees it
`timescale 1ns/100ps
module fpac_flash_model (
   input wire logic [15:0] pointer_register,
   output logic [7:0] flash_rdata
);
   // Address dependent, so a stale read shows
   assign flash_rdata = pointer_register[7:0] ^ pointer_register[15:8] ^ 8'h5a;
endmodule // fpac_flash_model

// ### tb.sv
// Self-checking bench of the flash control block
`timescale 1ns/100ps
module tb;
   import fpac_pkg::*;
   logic core_clk = 0, sys_rst = 1, xw = 0, pin = 0, stb = 1, crm = 0, cfe = 0, pcu = 0;
   logic [2:0] bvc = 0, bank = 0, lock;
   logic [15:0] xa = 0, ptr = 0, baddr;
   logic [7:0] xd = 0, frd, rdat, ldat, crd;
   logic [6:0] laddr;
   logic internal_expanded_ram, lat, start, busy, ext, boot;
   fpac_op_t op;
   fpac_sfr_t sfr_bus = '{1'b0, FPAC_CTRL_ADDR, 8'h00};
   logic [31:0] rnd = 32'ha2fc_534f;
   int mismatches = 0, checks = 0, n;
   always #25 core_clk = ~core_clk;
   fpac_flash_model fm (.pointer_register(ptr), .flash_rdata(frd));
   fpac_flash_ctrl #(.OP_CYCLES(4)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .sfr_bus(sfr_bus), .sfr_rdata(rdat), .xdata_wr(xw), .xdata_addr(xa), .xdata_wdata(xd),
      .external_access_pin(pin), .program_store_strobe(stb), .code_read_move(crm),
      .code_from_external(cfe), .pc_upper(pcu), .fetch_bank_select(bank),
      .pointer_register(ptr), .flash_rdata(frd), .boot_vector_config(bvc), .internal_expanded_ram_wr_q(internal_expanded_ram),
      .latch_wr_q(lat), .latch_addr_q(laddr), .latch_data_q(ldat), .flash_start_q(start),
      .flash_op_q(op), .busy_q(busy), .lock_level_bits_q(lock), .ext_code_sel_q(ext),
      .code_rdata_q(crd), .boot_request_q(boot), .boot_addr_q(baddr));
   // ****************************************
   // Helpers
   // ****************************************
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (e !== s) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   task final_report;
      if (mismatches == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task wr(input logic [7:0] d);
      @(posedge core_clk);
      sfr_bus <= '{1'b1, FPAC_CTRL_ADDR, d};
   endtask
   task key(input logic [7:0] a, input logic [7:0] b, input logic e);
      wr(a);
      wr(b);
      @(posedge core_clk);
      sfr_bus.wr <= 1'b0;
      #1 chk("start", e, start);
   endtask
   task rst(input logic p, input logic s, input logic [2:0] v);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      pin <= p;
      stb <= s;
      bvc <= v;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1 chk("boot", (p && !s) || v == 3'h3, boot);
      chk("ctrl", 0, rdat);
      chk("baddr", 16'h0000, baddr);
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      #100us;
      mismatches++;
      final_report;
   end
   initial begin
      rst(0, 1, 0);
      for (int i = 0; i < 3; i++) begin
         key({5'h0a, i[2:0]}, {5'h14, i[2:0]}, 1);
         chk("op", i, op);
         key(8'h51, 8'ha1, 0);
         for (n = 0; n < 20 && busy !== 1'b0; n++) begin
            @(posedge core_clk);
            #1;
         end
         chk("busy", 0, busy);
         chk("lock", 7, lock);
      end
      wr(8'h51);
      key(8'h07, 8'ha1, 0);
      repeat (32) begin
         rnd = lfsr(rnd);
         wr({4'h0, rnd[0], 3'h7});
         @(posedge core_clk);
         sfr_bus.wr <= 1'b0;
         xw <= 1;
         pin <= rnd[1];
         xa <= rnd[31:16];
         xd <= rnd[15:8];
         @(posedge core_clk);
         xw <= 0;
         #1 chk("latch", rnd[0] && rnd[1], lat);
         chk("internal_expanded_ram", !(rnd[0] && rnd[1]), internal_expanded_ram);
         if (lat === 1'b1) chk("ldat", {rnd[15:8], 1'b0, rnd[22:16]}, {ldat, 1'b0, laddr});
         @(posedge core_clk);
         crm <= 1;
         cfe <= rnd[2] | rnd[9];
         pin <= rnd[3];
         pcu <= rnd[4] | rnd[10];
         bank <= {1'b0, rnd[5], 1'b1};
         ptr <= rnd[31:16];
         @(posedge core_clk);
         crm <= 0;
         #1 chk("ext", cfe && (!pin || pcu && bank == 3 && ptr[15]), ext);
         if (cfe && pin && pcu && bank == 3 && !ptr[15]) chk("code", frd, crd);
      end
      rst(1, 0, 0);
      rst(0, 1, 3);
      rst(1, 1, 5);
      final_report;
   end
endmodule // tb
bind fpac_flash_ctrl fpac_flash_ctrl_assertions chk (.*);
